// file: src/viwc_defines.svh
// constants of the vectored interrupt and wake-up controller
// assumes the core's special-register port uses 8-bit addresses
`ifndef VIWC_DEFINES_SVH
`define VIWC_DEFINES_SVH

// register addresses on the special-register port
`define VIWC_ADDR_IE_MAIN   8'hA8
`define VIWC_ADDR_IE_EXT    8'hA9
`define VIWC_ADDR_SUB_EN    8'h84
`define VIWC_ADDR_FLAG_A    8'h95
`define VIWC_ADDR_FLAG_B    8'h85
`define VIWC_ADDR_LVL_LO_A  8'hB8
`define VIWC_ADDR_LVL_HI_A  8'hB9
`define VIWC_ADDR_LVL_LO_B  8'hBA
`define VIWC_ADDR_LVL_HI_B  8'hBB

// reset values
`define VIWC_RST_REG        8'h00

// writable masks
`define VIWC_MASK_IE_MAIN   8'hBF
`define VIWC_MASK_SUB_EN    8'h63
`define VIWC_MASK_FLAG_A    8'hF7
`define VIWC_MASK_FLAG_B    8'h60
`define VIWC_MASK_LVL_A     8'h3F

// field positions
`define VIWC_BIT_GLB_EN     7
`define VIWC_BIT_TMR3       0
`define VIWC_BIT_PORT       1
`define VIWC_BIT_XINT2      2
`define VIWC_BIT_ADC        4
`define VIWC_BIT_TOUCH      5
`define VIWC_BIT_CMPR       6
`define VIWC_BIT_LOWV       7
`define VIWC_BIT_PWM0       6
`define VIWC_BIT_PWM1       5
`define VIWC_SUB_ADC        1
`define VIWC_SUB_TOUCH      0
`define VIWC_SUB_PWM0       6
`define VIWC_SUB_PWM1       5

// vector layout
`define VIWC_NSRC           15
`define VIWC_RSVD_ID        4'h6
`define VIWC_VEC_BASE       16'h0003

`endif

// file: src/viwc_pkg.sv
// types shared by the interrupt controller and its arbiter
// assumes viwc_defines.svh is on the include path
package viwc_pkg;
	typedef logic [1:0] viwc_lvl_t;
	typedef logic [3:0] viwc_id_t;

	typedef struct packed {
		logic [7:0]  ie_main;
		logic [7:0]  ie_ext;
		logic [7:0]  sub_en;
		logic [7:0]  flag_a;
		logic [7:0]  flag_b;
		logic [7:0]  lvl_lo_a;
		logic [7:0]  lvl_hi_a;
		logic [7:0]  lvl_lo_b;
		logic [7:0]  lvl_hi_b;
		logic [3:0]  in_svc;
		logic        req;
		logic [15:0] vec;
		viwc_lvl_t   req_lvl;
		viwc_id_t    req_id;
		logic        svc;
		viwc_id_t    svc_id;
		logic        wake_idle;
		logic        wake_halt;
		logic [7:0]  rdata;
	} viwc_state_s;
endpackage

// file: src/viwc_arb_if.sv
// carrier between the controller and its priority arbiter
// assumes both ends sit on the same clock
`timescale 1ns/1ps
`default_nettype none
interface viwc_arb_if;
	import viwc_pkg::*;
	logic [14:0]      cand;
	logic [14:0][1:0] lvl;
	logic             best_vld;
	viwc_id_t         best_id;
	viwc_lvl_t        best_lvl;

	modport arb (input cand, input lvl,
		output best_vld, output best_id, output best_lvl);
	modport ctl (output cand, output lvl,
		input best_vld, input best_id, input best_lvl);
endinterface
`default_nettype wire

// file: src/viwc_arbiter.sv
// priority arbiter: highest level wins, lowest vector breaks ties
// assumes a purely combinational path inside one clock domain
`timescale 1ns/1ps
`default_nettype none
module viwc_arbiter
	import viwc_pkg::*;
(
	// candidate side
	viwc_arb_if.arb arb
);
	always_comb begin
		arb.best_vld = 1'b0;
		arb.best_id  = 4'h0;
		arb.best_lvl = 2'h0;
		// walk downward with >= so the lowest vector wins equal levels
		for (int i = 14; i >= 0; i--) begin
			if (arb.cand[i] && (!arb.best_vld || arb.lvl[i] >= arb.best_lvl)) begin
				arb.best_vld = 1'b1;
				arb.best_id  = 4'(i);
				arb.best_lvl = arb.lvl[i];
			end
		end
	end
endmodule
`default_nettype wire

// file: src/viwc_ctrl.sv
// vectored interrupt and wake-up controller, top level
// assumes sources and core share clk_sys; event inputs are 1-cycle pulses
//
// Operation
// - fourteen sources over four priority levels
// - any enabled source wakes from idle while glb is set
// - only pins, port change, timer3 wake halt
// - events set flags regardless of enables
// - first six vectors from 0003 to 002B
// - 0033 reserved; others 003B through 0073
// - shared vectors OR flags, sub-enables gate
// - flag register bit positions as listed
// - spi and iic flags share one vector
// - enables gate service, level registers rank
// - equal or higher in service blocks
// - higher level preempts, lower resumes later
// - global enable zero blocks every interrupt
// - main enable layout, reset to zero
// - pin enable also wakes halt, any glb
// - second enable layout, reset to zero
// - port enable leaves halt wake alone
// - level is high bit and low bit
`include "viwc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module viwc_ctrl
	import viwc_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	// special-register port
	input  wire logic [7:0]  sfr_addr,
	input  wire logic [7:0]  sfr_wdata,
	input  wire logic        sfr_wr,
	output logic      [7:0]  sfr_rdata,
	// flags held by the peripherals
	input  wire logic        xint0_flag,
	input  wire logic        xint1_flag,
	input  wire logic        tmr0_ovf_flag,
	input  wire logic        tmr1_ovf_flag,
	input  wire logic        tmr2_ovf_flag,
	input  wire logic        tmr2_ext_flag,
	input  wire logic        uart_rx_flag,
	input  wire logic        uart_tx_flag,
	input  wire logic        spi_flag,
	input  wire logic        iic_mst_flag,
	// event pulses for flags held here
	input  wire logic        tmr3_evt,
	input  wire logic        port_chg_evt,
	input  wire logic        xint2_evt,
	input  wire logic        adc_done_evt,
	input  wire logic        touch_evt,
	input  wire logic        cmpr_evt,
	input  wire logic        lowv_evt,
	input  wire logic        pwm0_evt,
	input  wire logic        pwm1_evt,
	// core handshake
	input  wire logic        irq_ack,
	input  wire logic        irq_ret,
	output logic             irq_req,
	output logic      [15:0] irq_vec,
	output logic             svc_pulse,
	output logic      [3:0]  svc_id,
	// wake-up
	output logic             wake_idle,
	output logic             wake_halt
);
	viwc_state_s st_reg;
	viwc_state_s st_next;
	viwc_arb_if  arb_if ();

	logic [14:0]      pend;
	logic [14:0]      en;
	logic [14:0][1:0] lvl;
	logic [14:0]      cand;
	logic             glb_irq_en;
	logic [2:0]       cur;

	// {busy, level} of the deepest service in progress
	function automatic logic [2:0] top_lvl(input logic [3:0] s);
		if (s[3])
			return 3'h7;
		else if (s[2])
			return 3'h6;
		else if (s[1])
			return 3'h5;
		else if (s[0])
			return 3'h4;
		return 3'h0;
	endfunction

	function automatic logic [15:0] vec_of(input viwc_id_t id);
		return `VIWC_VEC_BASE + {9'h000, id, 3'h0};
	endfunction

	viwc_arbiter u_arb (
		.arb (arb_if.arb)
	);

	////////////////////////////////////////////////////////////////////
	// sources, enables and levels

	always_comb begin
		glb_irq_en = st_reg.ie_main[`VIWC_BIT_GLB_EN];
		pend[0]  = xint0_flag;
		pend[1]  = tmr0_ovf_flag;
		pend[2]  = xint1_flag;
		pend[3]  = tmr1_ovf_flag;
		pend[4]  = uart_rx_flag | uart_tx_flag;
		pend[5]  = tmr2_ovf_flag | tmr2_ext_flag;
		pend[6]  = 1'b0;
		pend[7]  = st_reg.flag_a[`VIWC_BIT_TMR3];
		pend[8]  = st_reg.flag_a[`VIWC_BIT_PORT];
		pend[9]  = st_reg.flag_a[`VIWC_BIT_XINT2];
		pend[10] = (st_reg.flag_a[`VIWC_BIT_ADC]
			& st_reg.sub_en[`VIWC_SUB_ADC])
			| (st_reg.flag_a[`VIWC_BIT_TOUCH]
			& st_reg.sub_en[`VIWC_SUB_TOUCH]);
		pend[11] = spi_flag | iic_mst_flag;
		pend[12] = st_reg.flag_a[`VIWC_BIT_LOWV];
		pend[13] = st_reg.flag_a[`VIWC_BIT_CMPR];
		pend[14] = (st_reg.flag_b[`VIWC_BIT_PWM0]
			& st_reg.sub_en[`VIWC_SUB_PWM0])
			| (st_reg.flag_b[`VIWC_BIT_PWM1]
			& st_reg.sub_en[`VIWC_SUB_PWM1]);
		en = {st_reg.ie_ext, 1'b0, st_reg.ie_main[5:0]};
		for (int i = 0; i < 6; i++)
			lvl[i] = {st_reg.lvl_hi_a[i], st_reg.lvl_lo_a[i]};
		lvl[6] = 2'h0;
		for (int i = 0; i < 8; i++)
			lvl[i+7] = {st_reg.lvl_hi_b[i], st_reg.lvl_lo_b[i]};
		cand = pend & en & {15{glb_irq_en}};
		cur  = top_lvl(st_reg.in_svc);
	end

	assign arb_if.cand = cand;
	assign arb_if.lvl  = lvl;

	////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		st_next     = st_reg;
		st_next.svc = 1'b0;

		if (sfr_wr) begin
			case (sfr_addr)
			`VIWC_ADDR_IE_MAIN:  st_next.ie_main  = sfr_wdata & `VIWC_MASK_IE_MAIN;
			`VIWC_ADDR_IE_EXT:   st_next.ie_ext   = sfr_wdata;
			`VIWC_ADDR_SUB_EN:   st_next.sub_en   = sfr_wdata & `VIWC_MASK_SUB_EN;
			`VIWC_ADDR_FLAG_A:   st_next.flag_a   = sfr_wdata & `VIWC_MASK_FLAG_A;
			`VIWC_ADDR_FLAG_B:   st_next.flag_b   = sfr_wdata & `VIWC_MASK_FLAG_B;
			`VIWC_ADDR_LVL_LO_A: st_next.lvl_lo_a = sfr_wdata & `VIWC_MASK_LVL_A;
			`VIWC_ADDR_LVL_HI_A: st_next.lvl_hi_a = sfr_wdata & `VIWC_MASK_LVL_A;
			`VIWC_ADDR_LVL_LO_B: st_next.lvl_lo_b = sfr_wdata;
			`VIWC_ADDR_LVL_HI_B: st_next.lvl_hi_b = sfr_wdata;
			default: ;
			endcase
		end

		// events land after the write so a same-cycle clear loses
		if (tmr3_evt)     st_next.flag_a[`VIWC_BIT_TMR3]  = 1'b1;
		if (port_chg_evt) st_next.flag_a[`VIWC_BIT_PORT]  = 1'b1;
		if (xint2_evt)    st_next.flag_a[`VIWC_BIT_XINT2] = 1'b1;
		if (adc_done_evt) st_next.flag_a[`VIWC_BIT_ADC]   = 1'b1;
		if (touch_evt)    st_next.flag_a[`VIWC_BIT_TOUCH] = 1'b1;
		if (cmpr_evt)     st_next.flag_a[`VIWC_BIT_CMPR]  = 1'b1;
		if (lowv_evt)     st_next.flag_a[`VIWC_BIT_LOWV]  = 1'b1;
		if (pwm0_evt)     st_next.flag_b[`VIWC_BIT_PWM0]  = 1'b1;
		if (pwm1_evt)     st_next.flag_b[`VIWC_BIT_PWM1]  = 1'b1;

		// return retires the deepest level, resuming the one below
		if (irq_ret && cur[2])
			st_next.in_svc[cur[1:0]] = 1'b0;
		if (irq_ack && st_reg.req) begin
			st_next.in_svc[st_reg.req_lvl] = 1'b1;
			st_next.svc    = 1'b1;
			st_next.svc_id = st_reg.req_id;
		end

		// request dropped for a cycle after a take so it is not double taken
		st_next.req = arb_if.best_vld && !(irq_ack && st_reg.req)
			&& (!cur[2] || arb_if.best_lvl > cur[1:0]);
		st_next.req_lvl = arb_if.best_lvl;
		st_next.req_id  = arb_if.best_id;
		st_next.vec     = vec_of(arb_if.best_id);

		st_next.wake_idle = |cand;
		// pin wake ignores the global enable; port wake ignores its enable
		st_next.wake_halt = (xint0_flag & st_reg.ie_main[0])
			| (xint1_flag & st_reg.ie_main[2])
			| (st_reg.flag_a[`VIWC_BIT_XINT2] & st_reg.ie_ext[2])
			| st_reg.flag_a[`VIWC_BIT_PORT]
			| (st_reg.flag_a[`VIWC_BIT_TMR3] & st_reg.ie_ext[0]);

		case (sfr_addr)
		`VIWC_ADDR_IE_MAIN:  st_next.rdata = st_reg.ie_main;
		`VIWC_ADDR_IE_EXT:   st_next.rdata = st_reg.ie_ext;
		`VIWC_ADDR_SUB_EN:   st_next.rdata = st_reg.sub_en;
		`VIWC_ADDR_FLAG_A:   st_next.rdata = st_reg.flag_a;
		`VIWC_ADDR_FLAG_B:   st_next.rdata = st_reg.flag_b;
		`VIWC_ADDR_LVL_LO_A: st_next.rdata = st_reg.lvl_lo_a;
		`VIWC_ADDR_LVL_HI_A: st_next.rdata = st_reg.lvl_hi_a;
		`VIWC_ADDR_LVL_LO_B: st_next.rdata = st_reg.lvl_lo_b;
		`VIWC_ADDR_LVL_HI_B: st_next.rdata = st_reg.lvl_hi_b;
		default:             st_next.rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign sfr_rdata = st_reg.rdata;
	assign irq_req   = st_reg.req;
	assign irq_vec   = st_reg.vec;
	assign svc_pulse = st_reg.svc;
	assign svc_id    = st_reg.svc_id;
	assign wake_idle = st_reg.wake_idle;
	assign wake_halt = st_reg.wake_halt;

	////////////////////////////////////////////////////////////////////
	// checks

	sequence s_take;
		irq_ack && irq_req && !irq_ret;
	endsequence

	sequence s_marked(logic [1:0] l);
		st_reg.in_svc[l] && !irq_req;
	endsequence

	property p_take_nests;
		@(posedge clk_sys) disable iff (!arst_n)
		s_take |=> s_marked($past(st_reg.req_lvl)) ##1 svc_pulse == 1'b0;
	endproperty
	a_take_nests: assert property (p_take_nests)
		else $error("take did not mark its level in service");

	property p_flag_set;
		@(posedge clk_sys) disable iff (!arst_n)
		tmr3_evt |=> st_reg.flag_a[`VIWC_BIT_TMR3] ##1 (st_reg.flag_a[`VIWC_BIT_TMR3]
			|| $past(sfr_wr && sfr_addr == `VIWC_ADDR_FLAG_A));
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("timer3 event did not set its flag");

	property p_glb_block;
		@(posedge clk_sys) disable iff (!arst_n)
		!st_reg.ie_main[7] [*2] |=> !irq_req && !wake_idle;
	endproperty
	a_glb_block: assert property (p_glb_block)
		else $error("request raised with global enable off");

	property p_vec_addr;
		@(posedge clk_sys) disable iff (!arst_n)
		irq_req |-> irq_vec == 16'h0003 + {9'h000, st_reg.req_id, 3'h0};
	endproperty
	a_vec_addr: assert property (p_vec_addr)
		else $error("vector does not match source");

	property p_no_rsvd;
		@(posedge clk_sys) disable iff (!arst_n)
		irq_req |-> irq_vec != 16'h0033;
	endproperty
	a_no_rsvd: assert property (p_no_rsvd)
		else $error("reserved vector issued");

	property p_block_equal;
		@(posedge clk_sys) disable iff (!arst_n)
		irq_req && $past(st_reg.in_svc) == st_reg.in_svc
			|-> !cur[2] || st_reg.req_lvl > cur[1:0];
	endproperty
	a_block_equal: assert property (p_block_equal)
		else $error("request not above level in service");

	property p_pin_wake;
		@(posedge clk_sys) disable iff (!arst_n)
		xint0_flag && st_reg.ie_main[0] && !st_reg.ie_main[7]
			|=> wake_halt;
	endproperty
	a_pin_wake: assert property (p_pin_wake)
		else $error("pin wake missing without global enable");

	property p_port_wake;
		@(posedge clk_sys) disable iff (!arst_n)
		st_reg.flag_a[1] && !st_reg.ie_ext[1] |=> wake_halt;
	endproperty
	a_port_wake: assert property (p_port_wake)
		else $error("port wake lost with its enable off");

	property p_halt_only;
		@(posedge clk_sys) disable iff (!arst_n)
		wake_halt |-> $past(xint0_flag | xint1_flag | st_reg.flag_a[0]
			| st_reg.flag_a[1] | st_reg.flag_a[2]);
	endproperty
	a_halt_only: assert property (p_halt_only)
		else $error("halt wake from a source that may not wake");

	property p_idle_wake;
		@(posedge clk_sys) disable iff (!arst_n)
		|cand |=> wake_idle;
	endproperty
	a_idle_wake: assert property (p_idle_wake)
		else $error("enabled source failed to wake idle");
endmodule
`default_nettype wire

// file: tb/viwc_core_model.sv
// processor core model: takes a standing request after a set delay
// assumes clk_sys is shared with the controller; returns come from the bench
`timescale 1ns/1ps
`default_nettype none
module viwc_core_model (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       arst_n,
	// handshake
	input  wire logic       irq_req,
	input  wire logic [3:0] ack_dly,
	output logic            irq_ack
);
	int cnt;

	////////////////////////////////////////////////////////////////////////
	// ack only while a request stands; a dropped request restarts the wait
	always @(negedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cnt <= 0;
			irq_ack <= 1'b0;
		end else if (irq_ack || !irq_req) begin
			cnt <= 0;
			irq_ack <= 1'b0;
		end else if (cnt >= ack_dly) begin
			irq_ack <= 1'b1;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule
`default_nettype wire

// file: tb/tb_viwc_ctrl.sv
// self-checking bench for the interrupt and wake-up controller
// assumes the core model answers requests; inputs change at falling edges
`include "viwc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_viwc_ctrl;
	logic        clk_sys, arst_n, sfr_wr, irq_ack, irq_ret, irq_req;
	logic        svc_pulse, wake_idle, wake_halt;
	logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
	logic [9:0]  fl;
	logic [8:0]  ev;
	logic [15:0] irq_vec;
	logic [3:0]  svc_id, took, ack_dly;
	logic [3:0]  exp_q[$];
	logic [3:0]  sid[10] = '{0, 2, 1, 3, 5, 5, 4, 4, 11, 11};
	logic [7:0]  rem[4] = '{8'hC4, 8'hC0, 8'h40, 8'h00};
	logic [3:0]  ord[4] = '{4'h8, 4'h9, 4'hC, 4'hD};
	logic        pend_svc = 1'b0;
	logic [31:0] r;
	int          miscompares, n_compared, seed, i;

	viwc_ctrl viwc_ctrl_i (.clk_sys(clk_sys), .arst_n(arst_n),
		.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
		.sfr_rdata(sfr_rdata), .xint0_flag(fl[0]), .xint1_flag(fl[1]),
		.tmr0_ovf_flag(fl[2]), .tmr1_ovf_flag(fl[3]), .tmr2_ovf_flag(fl[4]),
		.tmr2_ext_flag(fl[5]), .uart_rx_flag(fl[6]), .uart_tx_flag(fl[7]),
		.spi_flag(fl[8]), .iic_mst_flag(fl[9]), .tmr3_evt(ev[0]),
		.port_chg_evt(ev[1]), .xint2_evt(ev[2]), .adc_done_evt(ev[3]),
		.touch_evt(ev[4]), .cmpr_evt(ev[5]), .lowv_evt(ev[6]),
		.pwm0_evt(ev[7]), .pwm1_evt(ev[8]), .irq_ack(irq_ack),
		.irq_ret(irq_ret), .irq_req(irq_req), .irq_vec(irq_vec),
		.svc_pulse(svc_pulse), .svc_id(svc_id), .wake_idle(wake_idle),
		.wake_halt(wake_halt));
	viwc_core_model viwc_core_model_i (.clk_sys(clk_sys), .arst_n(arst_n),
		.irq_req(irq_req), .ack_dly(ack_dly), .irq_ack(irq_ack));

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk_sys);
		sfr_wr = 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk_sys);
		sfr_addr = a;
		repeat (2) @(negedge clk_sys);
		chk({8'h00, sfr_rdata}, {8'h00, exp});
	endtask
	task automatic pulse(input logic [8:0] m);
		@(negedge clk_sys);
		ev = m;
		@(negedge clk_sys);
		ev = 9'h000;
	endtask
	task automatic ret;
		@(negedge clk_sys);
		irq_ret = 1'b1;
		@(negedge clk_sys);
		irq_ret = 1'b0;
	endtask
	task automatic settle;
		repeat (3) @(negedge clk_sys);
	endtask
	// bounded wait until only 'left' expected takes remain
	task automatic wait_q(input int left);
		for (int k = 0; k < 100 && exp_q.size() > left; k++)
			@(negedge clk_sys);
		chk(16'(exp_q.size()), 16'(left));
	endtask
	task automatic summarize;
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// a take pops the oldest note; vector spacing is eight from 0003
	// svc_pulse must follow every take by one edge and never come alone
	always @(posedge clk_sys) begin
		if (arst_n && (pend_svc || svc_pulse))
			chk({15'h0, svc_pulse}, {15'h0, pend_svc});
		if (arst_n && svc_pulse)
			chk({12'h000, svc_id}, {12'h000, took});
		pend_svc = arst_n && irq_req && irq_ack;
		if (pend_svc) begin
			took = (exp_q.size() > 0) ? exp_q.pop_front() : 4'hF;
			chk(irq_vec, 16'h0003 + {9'h000, took, 3'b000});
		end
	end

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	initial begin
		#200000;
		miscompares++;
		summarize;
	end

	initial begin
		seed = 20349;
		{sfr_addr, sfr_wdata, sfr_wr, irq_ret, fl, ev} = '0;
		ack_dly = 4'h2;
		arst_n = 1'b0;
		repeat (20) @(negedge clk_sys);
		arst_n = 1'b1;
		rchk(`VIWC_ADDR_IE_MAIN, 8'h00);
		rchk(`VIWC_ADDR_IE_EXT, 8'h00);
		wr(`VIWC_ADDR_IE_MAIN, 8'hFF);
		rchk(`VIWC_ADDR_IE_MAIN, 8'hBF);
		wr(8'h00, 8'hFF);
		rchk(8'h00, 8'h00);
		wr(`VIWC_ADDR_IE_MAIN, 8'h00);
		pulse(9'h001);
		rchk(`VIWC_ADDR_FLAG_A, 8'h01);
		wr(`VIWC_ADDR_IE_EXT, 8'h01);
		settle;
		chk({15'h0, irq_req}, 16'h0000);
		chk({15'h0, wake_halt}, 16'h0001);
		exp_q.push_back(4'h7);
		wr(`VIWC_ADDR_IE_MAIN, 8'h80);
		wait_q(0);
		wr(`VIWC_ADDR_FLAG_A, 8'h00);
		ret;
		// four level-0 sources at once: lowest vector first, one at a time
		wr(`VIWC_ADDR_IE_MAIN, 8'h00);
		pulse(9'h066);
		for (i = 0; i < 4; i++)
			exp_q.push_back(ord[i]);
		wr(`VIWC_ADDR_IE_EXT, 8'h66);
		wr(`VIWC_ADDR_IE_MAIN, 8'h80);
		for (i = 0; i < 4; i++) begin
			wait_q(3 - i);
			wr(`VIWC_ADDR_FLAG_A, rem[i]);
			ret;
		end
		// port flag wakes halt with its enable off; pin 0 with global off
		wr(`VIWC_ADDR_IE_EXT, 8'h00);
		wr(`VIWC_ADDR_IE_MAIN, 8'h01);
		pulse(9'h002);
		settle;
		chk({15'h0, wake_halt}, 16'h0001);
		chk({15'h0, wake_idle}, 16'h0000);
		wr(`VIWC_ADDR_FLAG_A, 8'h00);
		fl[0] = 1'b1;
		settle;
		chk({15'h0, wake_halt}, 16'h0001);
		chk({15'h0, irq_req}, 16'h0000);
		fl[0] = 1'b0;
		// level 3 low-voltage preempts a level-0 timer3 service
		wr(`VIWC_ADDR_LVL_LO_B, 8'h20);
		wr(`VIWC_ADDR_LVL_HI_B, 8'h20);
		wr(`VIWC_ADDR_IE_EXT, 8'h21);
		wr(`VIWC_ADDR_IE_MAIN, 8'h80);
		exp_q.push_back(4'h7);
		pulse(9'h001);
		wait_q(0);
		exp_q.push_back(4'hC);
		pulse(9'h040);
		wait_q(0);
		wr(`VIWC_ADDR_FLAG_A, 8'h00);
		ret;
		ret;
		settle;
		chk({15'h0, irq_req}, 16'h0000);
		// every peripheral-held flag, shared vectors included
		for (i = 0; i < 10; i++) begin
			exp_q.push_back(sid[i]);
			wr(`VIWC_ADDR_IE_EXT, i > 7 ? 8'h10 : 8'h00);
			wr(`VIWC_ADDR_IE_MAIN, i > 7 ? 8'h80 : 8'h80 | (8'h01 << sid[i]));
			@(negedge clk_sys);
			fl[i] = 1'b1;
			wait_q(0);
			fl = '0;
			ret;
		end
		// random sub-enables and event choice on the adc/touch vector
		wr(`VIWC_ADDR_IE_EXT, 8'h08);
		repeat (6) begin
			r = $random(seed);
			ack_dly = r[7:4];
			wr(`VIWC_ADDR_SUB_EN, r[7:0]);
			if (r[2] ? r[1] : r[0])
				exp_q.push_back(4'hA);
			pulse(r[2] ? 9'h008 : 9'h010);
			settle;
			chk({15'h0, wake_halt}, 16'h0000);
			chk({15'h0, wake_idle}, {15'h0, r[2] ? r[1] : r[0]});
			wait_q(0);
			wr(`VIWC_ADDR_FLAG_A, 8'h00);
			if (r[2] ? r[1] : r[0])
				ret;
		end
		// pwm0 masked by its sub-enable, pwm1 served
		wr(`VIWC_ADDR_SUB_EN, 8'h20);
		wr(`VIWC_ADDR_IE_EXT, 8'h80);
		pulse(9'h080);
		settle;
		chk({15'h0, irq_req}, 16'h0000);
		rchk(`VIWC_ADDR_FLAG_B, 8'h40);
		exp_q.push_back(4'hE);
		pulse(9'h100);
		wait_q(0);
		wr(`VIWC_ADDR_FLAG_B, 8'h00);
		ret;
		// mid-run reset must clear the ie_ext enable written above
		arst_n = 1'b0;
		repeat (2) @(negedge clk_sys);
		arst_n = 1'b1;
		rchk(`VIWC_ADDR_IE_EXT, 8'h00);
		summarize;
	end
endmodule
`default_nettype wire
